// [inc/phap_map.vh]
// register map, field layout, reset values and timing of the processor hot alert profile
`ifndef PHAP_MAP_VH
`define PHAP_MAP_VH

// ==========================================================
// register offsets (command codes)
`define PHAP_OFS_STATUS        8'h3a
`define PHAP_OFS_OPTION1       8'h3d

// ==========================================================
// field positions of the option register
`define PHAP_THR_MSB           15
`define PHAP_THR_LSB           10
`define PHAP_DEG_MSB           9
`define PHAP_DEG_LSB           8
`define PHAP_SRC_MSB           6
`define PHAP_SRC_LSB           0

// ==========================================================
// source bit positions, shared by enables and status
`define PHAP_SRC_COMPARATOR    6
`define PHAP_SRC_CRIT_INPUT    5
`define PHAP_SRC_NOM_INPUT     4
`define PHAP_SRC_DISCHARGE     3
`define PHAP_SRC_LOW_SYSV      2
`define PHAP_SRC_BATT_PRESENT  1
`define PHAP_SRC_ADAPTER_GOOD  0

// sources that stay usable with the adapter removed
`define PHAP_KEEP_ON_BATTERY   7'h4c

// ==========================================================
// reset values
`define PHAP_OPTION1_RESET     16'h8120
`define PHAP_WRITE_MASK        16'hff7f

// ==========================================================
// timing, printed figures in ns, clock period in ns
`define PHAP_CLK_NS            20
`define PHAP_DEG00_NS          1600000
`define PHAP_DEG01_NS          100000
`define PHAP_DEG10_NS          6000000
`define PHAP_DEG11_NS          12000000
`define PHAP_PW00_NS           100000
`define PHAP_PW01_NS           1000000
`define PHAP_PW10_NS           10000000
`define PHAP_PW11_NS           5000000
`define PHAP_CYC(ns)           (((ns) + `PHAP_CLK_NS - 1) / `PHAP_CLK_NS)

// discharge threshold step as a left shift of the code, 512 mA per code step
`define PHAP_THR_STEP_SHIFT    9

`endif

// [hdl/phap_core.v]
// processor hot alert profile: source selection, discharge trigger, alert pulse and status
// ==========================================================
`timescale 1ns/10ps
`include "phap_map.vh"

module phap_core #(
   parameter DEG00_CYC = `PHAP_CYC(`PHAP_DEG00_NS),
   parameter DEG01_CYC = `PHAP_CYC(`PHAP_DEG01_NS),
   parameter DEG10_CYC = `PHAP_CYC(`PHAP_DEG10_NS),
   parameter DEG11_CYC = `PHAP_CYC(`PHAP_DEG11_NS),
   parameter PW00_CYC  = `PHAP_CYC(`PHAP_PW00_NS),
   parameter PW01_CYC  = `PHAP_CYC(`PHAP_PW01_NS),
   parameter PW10_CYC  = `PHAP_CYC(`PHAP_PW10_NS),
   parameter PW11_CYC  = `PHAP_CYC(`PHAP_PW11_NS)
) (
   // clock and reset
   input  wire        mclk_i,
   input  wire        rst_n_i,
   // register access, one command per strobe
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   input  wire [7:0]  reg_cmd_i,
   input  wire [15:0] reg_wdata_i,
   output wire [15:0] reg_rdata_o,
   // trigger sources
   input  wire        comparator_trip_i,
   input  wire        critical_input_current_i,
   input  wire        nominal_input_current_i,
   input  wire        low_system_voltage_i,
   input  wire [15:0] battery_discharge_current_i,
   input  wire        battery_present_detect_i,
   input  wire        adapter_good_i,
   // pulse shaping settings
   input  wire [1:0]  alert_min_pulse_width_i,
   input  wire        alert_pulse_extension_enable_i,
   input  wire        alert_pulse_clear_i,
   // alert pin, active low
   output wire        processor_hot_alert_n_o
);

   // ==========================================================
   // functions
   function [19:0] phap_deg_cycles;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    phap_deg_cycles = DEG00_CYC[19:0];
            2'h1:    phap_deg_cycles = DEG01_CYC[19:0];
            2'h2:    phap_deg_cycles = DEG10_CYC[19:0];
            default: phap_deg_cycles = DEG11_CYC[19:0];
         endcase
      end
   endfunction

   function [19:0] phap_pw_cycles;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    phap_pw_cycles = PW00_CYC[19:0];
            2'h1:    phap_pw_cycles = PW01_CYC[19:0];
            2'h2:    phap_pw_cycles = PW10_CYC[19:0];
            default: phap_pw_cycles = PW11_CYC[19:0];
         endcase
      end
   endfunction

   // ==========================================================
   // state
   reg  [15:0] option_ff;
   reg  [6:0]  status_ff;
   reg  [15:0] rdata_ff;
   reg  [19:0] deg_cnt_ff;
   reg  [19:0] pw_cnt_ff;
   reg         alert_ff;
   reg         ext_hold_ff;
   reg         batt_prev_ff;
   reg         adapter_prev_ff;
   reg  [15:0] nxt_option;
   reg  [15:0] nxt_rdata;
   reg  [6:0]  nxt_status;
   reg  [19:0] nxt_pw_cnt;
   reg         nxt_alert;
   reg         nxt_ext_hold;

   wire [5:0]  thr_code   = option_ff[`PHAP_THR_MSB:`PHAP_THR_LSB];
   wire [1:0]  deg_sel    = option_ff[`PHAP_DEG_MSB:`PHAP_DEG_LSB];
   wire [6:0]  src_enable = option_ff[`PHAP_SRC_MSB:`PHAP_SRC_LSB];
   wire [19:0] deg_target = phap_deg_cycles(deg_sel);
   wire [19:0] pw_target  = phap_pw_cycles(alert_min_pulse_width_i);

   // ==========================================================
   // discharge comparison and deglitch
   wire [15:0] thr_ma     = {thr_code, 10'h000} >> 1;
   wire        dchg_over  = battery_discharge_current_i > thr_ma;
   wire        dchg_trip  = dchg_over && (deg_cnt_ff >= deg_target);

   // ==========================================================
   // source vector and effective enables
   wire        batt_rise  = battery_present_detect_i & ~batt_prev_ff;
   wire        adpt_fall  = adapter_prev_ff & ~adapter_good_i;
   wire [6:0]  src_raw    = {comparator_trip_i, critical_input_current_i, nominal_input_current_i,
                             dchg_trip, low_system_voltage_i, batt_rise, adpt_fall};
   // the removal edge is the adapter source's own event, so its enable survives the removal,
   // while the other adapter-bound sources are cut in the very cycle the adapter goes
   wire [6:0]  eff_enable = adapter_good_i ? src_enable
                                           : (src_enable & (`PHAP_KEEP_ON_BATTERY | 7'h01));
   wire [6:0]  fired      = src_raw & eff_enable;
   wire        any_fired  = |fired;
   wire        width_done = (pw_cnt_ff >= pw_target);
   wire        rd_status  = reg_rd_i && (reg_cmd_i == `PHAP_OFS_STATUS);

   // the counter saturates at the target, so a long overload never wraps back below it
   wire [19:0] nxt_deg_cnt = !dchg_over ? 20'h00000 :
                             (deg_cnt_ff >= deg_target) ? deg_cnt_ff : deg_cnt_ff + 20'h00001;

   // ==========================================================
   // register access
   always @* begin
      nxt_option = option_ff;
      nxt_rdata  = rdata_ff;
      if (reg_wr_i && (reg_cmd_i == `PHAP_OFS_OPTION1)) begin
         // the reserved bit always reads back as zero
         nxt_option = reg_wdata_i & `PHAP_WRITE_MASK;
      end
      // a read in the same cycle as a write still returns the old contents
      if (reg_rd_i) begin
         case (reg_cmd_i)
            `PHAP_OFS_OPTION1: nxt_rdata = option_ff;
            `PHAP_OFS_STATUS:  nxt_rdata = {9'h000, status_ff};
            default:           nxt_rdata = 16'h0000;
         endcase
      end
   end

   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         option_ff       <= `PHAP_OPTION1_RESET;
         rdata_ff        <= 16'h0000;
         deg_cnt_ff      <= 20'h00000;
         batt_prev_ff    <= 1'b0;
         adapter_prev_ff <= 1'b0;
      end else begin
         option_ff       <= nxt_option;
         rdata_ff        <= nxt_rdata;
         deg_cnt_ff      <= nxt_deg_cnt;
         batt_prev_ff    <= battery_present_detect_i;
         adapter_prev_ff <= adapter_good_i;
      end
   end

   // ==========================================================
   // alert pulse and status
   always @* begin
      nxt_alert    = alert_ff;
      nxt_ext_hold = ext_hold_ff;
      nxt_pw_cnt   = pw_cnt_ff;
      nxt_status   = status_ff;
      if (!alert_ff) begin
         nxt_pw_cnt = 20'h00000;
         if (any_fired) begin
            nxt_alert    = 1'b1;
            nxt_ext_hold = alert_pulse_extension_enable_i;
            // a new pulse drops whatever the previous one left behind
            nxt_status   = fired;
         end else if (rd_status) begin
            nxt_status   = 7'h00;
         end
      end else begin
         nxt_status = status_ff | fired;
         if (!width_done) begin
            nxt_pw_cnt = pw_cnt_ff + 20'h00001;
         end
         if (alert_pulse_clear_i) begin
            nxt_ext_hold = 1'b0;
         end
         // the pin stays low while a source is still active, so a long event never splits
         if (width_done && !any_fired && !ext_hold_ff) begin
            nxt_alert = 1'b0;
         end
      end
   end

   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         alert_ff    <= 1'b0;
         ext_hold_ff <= 1'b0;
         pw_cnt_ff   <= 20'h00000;
         status_ff   <= 7'h00;
      end else begin
         alert_ff    <= nxt_alert;
         ext_hold_ff <= nxt_ext_hold;
         pw_cnt_ff   <= nxt_pw_cnt;
         status_ff   <= nxt_status;
      end
   end

   assign reg_rdata_o             = rdata_ff;
   assign processor_hot_alert_n_o = ~alert_ff;

endmodule // phap_core

// [sim/phap_core_asserts.sv]
// port assertions of the alert profile core
`timescale 1ns/10ps
module phap_core_asserts (
   // watched ports
   input wire        mclk_i,
   input wire        rst_n_i,
   input wire        reg_wr_i,
   input wire        reg_rd_i,
   input wire [7:0]  reg_cmd_i,
   input wire [15:0] reg_wdata_i,
   input wire [15:0] reg_rdata_o,
   input wire        comparator_trip_i,
   input wire        critical_input_current_i,
   input wire        adapter_good_i,
   input wire        processor_hot_alert_n_o
);
   // ==========
   // enable shadow
   reg [6:0] en_ff;
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) en_ff <= 7'h20;
      else if (reg_wr_i && reg_cmd_i == 8'h3d) en_ff <= reg_wdata_i[6:0];
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   property p_cmp; comparator_trip_i && en_ff[6] |=> !processor_hot_alert_n_o; endproperty
   a_cmp: assert property (p_cmp) else $error("no alert");
   property p_crit; critical_input_current_i && en_ff[5] && adapter_good_i && $past(adapter_good_i)
      |=> !processor_hot_alert_n_o; endproperty
   a_crit: assert property (p_crit) else $error("no alert");
   property p_quiet; en_ff == 7'h00 && $past(en_ff) == 7'h00 && processor_hot_alert_n_o
      |=> processor_hot_alert_n_o; endproperty
   a_quiet: assert property (p_quiet) else $error("alert");
   property p_width; $fell(processor_hot_alert_n_o) |=> !processor_hot_alert_n_o [*4]; endproperty
   a_width: assert property (p_width) else $error("short pulse");
   property p_opt; reg_rd_i && reg_cmd_i == 8'h3d |=> reg_rdata_o[7:0] == {1'b0, $past(en_ff)}; endproperty
   a_opt: assert property (p_opt) else $error("bad enables");
   property p_stat; reg_rd_i && reg_cmd_i == 8'h3a |=> reg_rdata_o[15:7] == 9'h000; endproperty
   a_stat: assert property (p_stat) else $error("bad status");
   property p_bad; reg_rd_i && reg_cmd_i != 8'h3a && reg_cmd_i != 8'h3d |=> reg_rdata_o == 16'h0000; endproperty
   a_bad: assert property (p_bad) else $error("bad read");
   property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
endmodule // phap_core_asserts

// [sim/phap_host.sv]
// host model issuing register commands
`timescale 1ns/10ps
module phap_host (
   // clock
   input  wire        mclk_i,
   // register strobes
   output reg         wr_o = 1'b0,
   output reg         rd_o = 1'b0,
   output reg  [7:0]  cmd_o = 8'h00,
   output reg  [15:0] wdata_o = 16'h0000
);
   // ==========
   // one command, strobe for one edge
   task xfer(input w, input [7:0] c, input [15:0] d);
      begin
         wr_o <= w;
         rd_o <= !w;
         cmd_o <= c;
         wdata_o <= d;
         @(posedge mclk_i);
         wr_o <= 1'b0;
         rd_o <= 1'b0;
         wdata_o <= ~d;
         @(posedge mclk_i);
      end
   endtask
endmodule // phap_host

// [sim/phap_core_bench.sv]
// self-checking bench of the alert profile core
`timescale 1ns/10ps
module phap_core_bench;
   // ==========
   // stimulus and model
   reg         mclk_i = 1'b0;
   reg         rst_n_i = 1'b0;
   reg  [6:0]  src = 7'h00;
   reg  [15:0] cur = 16'h0000;
   reg  [1:0]  pw = 2'b00;
   reg  [15:0] m_opt = 16'h8120;
   reg         ext = 1'b0;
   reg         clr = 1'b0;
   wire        reg_wr_i;
   wire        reg_rd_i;
   wire [7:0]  reg_cmd_i;
   wire [15:0] reg_wdata_i;
   wire [15:0] reg_rdata_o;
   wire        processor_hot_alert_n_o;
   integer     mismatches = 0;
   integer     checks = 0;
   integer     seed;
   initial forever #10 mclk_i = ~mclk_i;
   phap_host phap_host_inst (.mclk_i, .wr_o(reg_wr_i), .rd_o(reg_rd_i), .cmd_o(reg_cmd_i), .wdata_o(reg_wdata_i));
   // short counts keep the run brief
   localparam integer T_DEG00 = 12;
   localparam integer T_DEG01 = 8;
   localparam integer T_DEG10 = 16;
   localparam integer T_DEG11 = 20;
   localparam integer T_PW00  = 6;
   localparam integer T_PW01  = 10;
   localparam integer T_PW10  = 14;
   localparam integer T_PW11  = 12;
   phap_core #(.DEG00_CYC(T_DEG00), .DEG01_CYC(T_DEG01), .DEG10_CYC(T_DEG10), .DEG11_CYC(T_DEG11),
      .PW00_CYC(T_PW00), .PW01_CYC(T_PW01), .PW10_CYC(T_PW10), .PW11_CYC(T_PW11)) phap_core_inst (.mclk_i,
      .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_cmd_i,
      .reg_wdata_i, .reg_rdata_o, .comparator_trip_i(src[6]), .critical_input_current_i(src[5]),
      .nominal_input_current_i(src[4]), .low_system_voltage_i(src[2]), .battery_discharge_current_i(cur),
      .battery_present_detect_i(src[1]), .adapter_good_i(!src[0]), .alert_min_pulse_width_i(pw),
      .alert_pulse_extension_enable_i(ext), .alert_pulse_clear_i(clr), .processor_hot_alert_n_o);
   task cmp(input [15:0] got, input [15:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task rd(input [7:0] c, input [15:0] exp);
      begin
         phap_host_inst.xfer(1'b0, c, 16'h0000);
         cmp(reg_rdata_o, exp);
      end
   endtask
   task wr(input [15:0] d);
      begin
         m_opt = d & 16'hff7f;
         phap_host_inst.xfer(1'b1, 8'h3d, d);
      end
   endtask
   // src bit 0 high means adapter removed; bits 1..0 stay as levels after release
   task pulse(input [6:0] s, input [15:0] c);
      integer n;
      integer dg;
      reg [6:0] e;
      reg low;
      begin
         case (m_opt[9:8])
            2'b00:   dg = T_DEG00;
            2'b01:   dg = T_DEG01;
            2'b10:   dg = T_DEG10;
            default: dg = T_DEG11;
         endcase
         // the current stands for 13 edges, so only a deglitch count up to 12 lets it fire
         e = {s[6:4], c > {m_opt[15:10], 9'h000} && dg <= 12, s[2], s[1] & !src[1], s[0] & !src[0]};
         e = e & m_opt[6:0] & (s[0] ? 7'h4d : 7'h7f);
         low = 1'b0;
         pw <= $urandom % 4;
         src <= s;
         cur <= c;
         for (n = 0; n < 200; n = n + 1) begin
            @(posedge mclk_i);
            if (n == 12) src <= s & 7'h03;
            if (n == 12) cur <= $urandom % 512;
            if (!processor_hot_alert_n_o) low = 1'b1;
         end
         cmp({15'h0000, low}, {15'h0000, e != 7'h00});
         rd(8'h3a, {9'h000, e});
         rd(8'h3a, 16'h0000);
      end
   endtask
   // extension keeps the pin low after the source is gone, until the clear strobe
   task ext_run;
      begin
         ext <= 1'b1;
         src <= 7'h40;
         repeat (14) @(posedge mclk_i);
         ext <= 1'b0;
         src <= 7'h00;
         repeat (40) @(posedge mclk_i);
         cmp({15'h0000, processor_hot_alert_n_o}, 16'h0000);
         rd(8'h3a, 16'h0040);
         clr <= 1'b1;
         @(posedge mclk_i);
         clr <= 1'b0;
         repeat (2) @(posedge mclk_i);
         cmp({15'h0000, processor_hot_alert_n_o}, 16'h0001);
         rd(8'h3a, 16'h0040);
         rd(8'h3a, 16'h0000);
      end
   endtask
   task finish_test;
      begin
         if (mismatches == 0 && checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   initial begin
      seed = $urandom(2945);
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rd(8'h3d, 16'h8120);
      rd(8'h00, 16'h0000);
      pulse(7'h20, 16'h0000);
      wr(16'hffff);
      rd(8'h3d, 16'hff7f);
      wr(16'h0000);
      pulse(7'h76, 16'h2000);
      wr(16'h057f);
      pulse(7'h08, 16'h0201);
      pulse(7'h00, 16'h0200);
      wr(16'h067f);
      pulse(7'h00, 16'h0201);
      wr(16'h047f);
      pulse(7'h00, 16'h0201);
      pulse(7'h02, 16'h0000);
      pulse(7'h22, 16'h0000);
      ext_run;
      pulse(7'h01, 16'h0000);
      pulse(7'h33, 16'h0000);
      pulse(7'h45, 16'h0000);
      pulse(7'h00, 16'h0000);
      pulse(7'h21, 16'h0000);
      rst_n_i <= 1'b0;
      @(posedge mclk_i);
      rst_n_i <= 1'b1;
      m_opt = 16'h8120;
      rd(8'h3d, 16'h8120);
      rd(8'h3a, 16'h0000);
      finish_test;
   end
endmodule // phap_core_bench
bind phap_core phap_core_asserts phap_core_asserts_inst (.mclk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_cmd_i,
   .reg_wdata_i, .reg_rdata_o, .comparator_trip_i, .critical_input_current_i, .adapter_good_i,
   .processor_hot_alert_n_o);
